// >>> mdps_pkg.sv
// Package with constants for the multi data pointer select block
package mdps_pkg;
    localparam int PTR_W = 16;
    localparam int NUM_PTR = 8;
    localparam int SEL_W = 3;
    localparam logic [7:0] SFR_SELECT_ADDR = 8'h92;
    localparam logic [7:0] SFR_HIGH_ADDR = 8'h83;
    localparam logic [7:0] SFR_LOW_ADDR = 8'h82;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [4:0] SEL_RSVD_READ = 5'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 2;
    typedef enum logic [1:0] {
        MDPS_OP_NONE = 2'b00,
        MDPS_OP_LOAD = 2'b01,
        MDPS_OP_INC = 2'b10
    } mdps_op_t;
endpackage

// >>> mdps_ptr_if.sv
// Interface carrying write and read traffic of the pointer store
`timescale 1ns/10ps
interface mdps_ptr_if;
    logic [2:0] wrIdx;
    logic wrHighEn;
    logic wrLowEn;
    logic [15:0] wrData;
    logic [2:0] rdIdx;
    logic [15:0] rdData;
    modport ctrl (
        output wrIdx,
        output wrHighEn,
        output wrLowEn,
        output wrData,
        output rdIdx,
        input rdData
    );
    modport store (
        input wrIdx,
        input wrHighEn,
        input wrLowEn,
        input wrData,
        input rdIdx,
        output rdData
    );
endinterface

// >>> mdps_ptr_store.sv
// Eight-entry pointer memory with byte writes and registered read
`timescale 1ns/10ps
module mdps_ptr_store
    import mdps_pkg::*;
#(
    parameter int DEPTH = NUM_PTR,
    parameter int WIDTH = PTR_W
) (
    input wire logic clock,
    input wire logic nrst,
    mdps_ptr_if.store bus
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] rdData_ff;

    ////////////////////////////////////////////////////////////////
    // Only the addressed entry changes; others hold their value
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= PTR_RESET;
            end
        end else begin
            if (bus.wrHighEn) begin
                mem_ff[bus.wrIdx][15:8] <= bus.wrData[15:8];
            end
            if (bus.wrLowEn) begin
                mem_ff[bus.wrIdx][7:0] <= bus.wrData[7:0];
            end
        end
    end

    // Registered read port; takes the entry as it stood before this edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdData_ff <= PTR_RESET;
        end else begin
            rdData_ff <= mem_ff[bus.rdIdx];
        end
    end

    assign bus.rdData = rdData_ff;
endmodule

// >>> mdps_select.sv
// Multi data pointer bank with select register and pointer access
`timescale 1ns/10ps
module mdps_select
    import mdps_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    output logic sfrRdHit,
    input wire mdps_op_t ptrOp,
    input wire logic [15:0] ptrImm,
    input wire logic extAccess,
    output logic [15:0] dataPointer,
    output logic [7:0] port2Addr,
    output logic port2AddrEn,
    output logic [2:0] activeSlot
);
    logic [2:0] pointerSelectReg_ff;
    logic [15:0] shadow_ff;
    logic [7:0] sfrRdData_ff;
    logic sfrRdHit_ff;
    logic [15:0] nxt_shadow;
    logic hiWr;
    logic loWr;
    logic selWr;
    logic [15:0] curPtr;
    logic readSettle_ff;

    mdps_ptr_if pif ();

    mdps_ptr_store #(
        .DEPTH(NUM_PTR),
        .WIDTH(PTR_W)
    ) uStore (
        .clock(clock),
        .nrst(nrst),
        .bus(pif.store)
    );

    // Match one special function address on a strobe
    function automatic logic sfrHit(input logic [7:0] a, input logic [7:0] target,
                                    input logic en);
        return en && (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Select register
    assign selWr = sfrHit(sfrAddr, SFR_SELECT_ADDR, sfrWrEn);

    // Only the low field is stored; reserved bits are not kept
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pointerSelectReg_ff <= SEL_RESET;
        end else if (selWr) begin
            pointerSelectReg_ff <= sfrWrData[SEL_MSB:SEL_LSB];
        end
    end

    assign activeSlot = pointerSelectReg_ff;

    ////////////////////////////////////////////////////////////////
    // Pointer access decode; all writes address the selected slot
    assign hiWr = sfrHit(sfrAddr, SFR_HIGH_ADDR, sfrWrEn);
    assign loWr = sfrHit(sfrAddr, SFR_LOW_ADDR, sfrWrEn);

    // Shadow copy of the selected slot avoids a read-after-write bubble
    assign curPtr = shadow_ff;

    always_comb begin
        nxt_shadow = curPtr;
        case (ptrOp)
            MDPS_OP_LOAD: nxt_shadow = ptrImm;
            MDPS_OP_INC: nxt_shadow = curPtr + 16'h0001;
            default: nxt_shadow = curPtr;
        endcase
        if (hiWr) begin
            nxt_shadow[15:8] = sfrWrData;
        end
        if (loWr) begin
            nxt_shadow[7:0] = sfrWrData;
        end
    end

    // Store writes go to the selected slot only
    assign pif.wrIdx = pointerSelectReg_ff;
    assign pif.wrHighEn = (ptrOp != MDPS_OP_NONE) || hiWr;
    assign pif.wrLowEn = (ptrOp != MDPS_OP_NONE) || loWr;
    assign pif.wrData = nxt_shadow;
    // Reads follow the pending select so the shadow refills after a switch
    assign pif.rdIdx = selWr ? sfrWrData[SEL_MSB:SEL_LSB] : pointerSelectReg_ff;

    // After a select change the store read lands one cycle later
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readSettle_ff <= 1'b0;
        end else begin
            readSettle_ff <= selWr;
        end
    end

    // Shadow reloads from the store on a switch; pointers keep contents
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shadow_ff <= PTR_RESET;
        end else if (readSettle_ff) begin
            shadow_ff <= pif.rdData;
        end else begin
            shadow_ff <= nxt_shadow;
        end
    end

    // Software must not issue a pointer op in the cycle after a select write
    assign dataPointer = readSettle_ff ? pif.rdData : shadow_ff;

    ////////////////////////////////////////////////////////////////
    // External address high byte on port 2 during indirect access
    assign port2Addr = dataPointer[15:8];
    assign port2AddrEn = extAccess;

    ////////////////////////////////////////////////////////////////
    // Registered read data; reserved bits read as zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sfrRdData_ff <= 8'h00;
            sfrRdHit_ff <= 1'b0;
        end else begin
            sfrRdHit_ff <= 1'b0;
            sfrRdData_ff <= 8'h00;
            if (sfrHit(sfrAddr, SFR_SELECT_ADDR, sfrRdEn)) begin
                sfrRdData_ff <= {SEL_RSVD_READ, pointerSelectReg_ff};
                sfrRdHit_ff <= 1'b1;
            end else if (sfrHit(sfrAddr, SFR_HIGH_ADDR, sfrRdEn)) begin
                sfrRdData_ff <= dataPointer[15:8];
                sfrRdHit_ff <= 1'b1;
            end else if (sfrHit(sfrAddr, SFR_LOW_ADDR, sfrRdEn)) begin
                sfrRdData_ff <= dataPointer[7:0];
                sfrRdHit_ff <= 1'b1;
            end
        end
    end

    assign sfrRdData = sfrRdData_ff;
    assign sfrRdHit = sfrRdHit_ff;
endmodule

// >>> mdps_select_chk.sv
// Port checker for the data pointer bank
`timescale 1ns/10ps
module mdps_select_chk
    import mdps_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrWrData,
    input wire logic [7:0] sfrRdData,
    input wire logic sfrRdHit,
    input wire mdps_op_t ptrOp,
    input wire logic [15:0] ptrImm,
    input wire logic extAccess,
    input wire logic [15:0] dataPointer,
    input wire logic [7:0] port2Addr,
    input wire logic port2AddrEn,
    input wire logic [2:0] activeSlot
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Strobes that start a register access
    sequence selWr;
        sfrWrEn && sfrAddr == SFR_SELECT_ADDR;
    endsequence
    sequence selRd;
        sfrRdEn && sfrAddr == SFR_SELECT_ADDR;
    endsequence
    a_sel_write: assert property (selWr |=> {5'h00, activeSlot} == ($past(sfrWrData) & 8'h07))
        else $error("select write not taken");
    a_sel_hold: assert property (!sfrWrEn |=> $stable(activeSlot))
        else $error("select moved without write");
    a_sel_read: assert property (selRd |=> sfrRdHit && sfrRdData == {SEL_RSVD_READ, $past(activeSlot)})
        else $error("select read wrong");
    a_high_read: assert property (sfrRdEn && sfrAddr == SFR_HIGH_ADDR && !sfrWrEn |=> sfrRdData == $past(port2Addr))
        else $error("high byte read wrong");
    a_ptr_load: assert property (ptrOp == MDPS_OP_LOAD && !sfrWrEn |=> dataPointer == $past(ptrImm))
        else $error("load not seen");
    a_ptr_inc: assert property (ptrOp == MDPS_OP_INC && !sfrWrEn |=> dataPointer == $past(dataPointer) + 16'h0001)
        else $error("increment wrong");
    a_port2_high: assert property (port2AddrEn |-> port2Addr == dataPointer[15:8])
        else $error("port 2 byte wrong");
    a_port2_en: assert property (extAccess |-> port2AddrEn ##1 (port2AddrEn == extAccess))
        else $error("port 2 enable wrong");
    a_unmapped_read: assert property (sfrRdEn && sfrAddr > 8'h92 |=> !sfrRdHit && sfrRdData == 8'h00)
        else $error("unmapped read answered");
endmodule
bind mdps_select mdps_select_chk i_chk(.clock, .nrst, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData,
    .sfrRdData, .sfrRdHit, .ptrOp, .ptrImm, .extAccess, .dataPointer, .port2Addr, .port2AddrEn,
    .activeSlot);

// >>> mdps_core_model.sv
// Core side model issuing external moves and watching port 2
`timescale 1ns/10ps
module mdps_core_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic moveReq,
    input wire logic [7:0] port2Addr,
    output logic extAccess,
    output logic [7:0] seenHigh
);
    // Access level follows the request, changed off the sampling edge
    always_ff @(negedge clock or negedge nrst) begin
        if (!nrst) extAccess <= 1'b0;
        else extAccess <= moveReq;
    end
    // Upper address byte is taken while the access is on
    always_ff @(posedge clock) begin
        if (extAccess) seenHigh <= port2Addr;
    end
endmodule

// >>> testbench.sv
// Self-checking bench for the data pointer bank
`timescale 1ns/10ps
module testbench;
    import mdps_pkg::*;
    logic clock = 0, nrst = 0, sfrWrEn = 0, sfrRdEn = 0, moveReq = 0, sfrRdHit, port2AddrEn, extAccess;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, port2Addr, seenHigh;
    mdps_op_t ptrOp = MDPS_OP_NONE;
    logic [15:0] ptrImm = 16'h0000, dataPointer;
    logic [2:0] activeSlot;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    mdps_select i_mdps_select(.clock, .nrst, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
        .sfrRdHit, .ptrOp, .ptrImm, .extAccess, .dataPointer, .port2Addr, .port2AddrEn, .activeSlot);
    mdps_core_model i_core(.clock, .nrst, .moveReq, .port2Addr, .extAccess, .seenHigh);
    ////////////////////////////////////////////////////////////
    // Clock and hang guard; a stuck run ends as a mismatch
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Bus cycles, each starting one idle cycle after the last
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock); sfrAddr = a; sfrWrData = d; sfrWrEn = 1;
        @(negedge clock); sfrWrEn = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(negedge clock); sfrAddr = a; sfrRdEn = 1;
        @(negedge clock); sfrRdEn = 0;
        chk({7'h00, sfrRdHit, sfrRdData}, {7'h00, h, e});
    endtask
    task op(input mdps_op_t o, input logic [15:0] v);
        @(negedge clock); ptrOp = o; ptrImm = v;
        @(negedge clock); ptrOp = MDPS_OP_NONE;
    endtask
    ////////////////////////////////////////////////////////////
    // Load every slot, then revisit in reverse with reserved bits set
    task t_slots;
        for (int i = 0; i < 8; i++) begin
            wr(SFR_SELECT_ADDR, 8'(i));
            op(MDPS_OP_LOAD, {8'(i), 8'h5a});
        end
        for (int i = 7; i >= 0; i--) begin
            wr(SFR_SELECT_ADDR, 8'hf8 | 8'(i));
            rd(SFR_SELECT_ADDR, 8'(i), 1);
            chk({13'h0000, activeSlot}, 16'(i));
            chk(dataPointer, {8'(i), 8'h5a});
            rd(SFR_HIGH_ADDR, 8'(i), 1);
            rd(SFR_LOW_ADDR, 8'h5a, 1);
        end
        $display("slots done");
    endtask
    // Byte writes, increment with carry and wrap, then an external move
    task t_ops;
        wr(SFR_SELECT_ADDR, 8'h03);
        wr(SFR_HIGH_ADDR, 8'hab);
        wr(SFR_LOW_ADDR, 8'hcd);
        chk(dataPointer, 16'habcd);
        op(MDPS_OP_LOAD, 16'h00ff);
        op(MDPS_OP_INC, 16'h0000);
        chk(dataPointer, 16'h0100);
        op(MDPS_OP_LOAD, 16'hffff);
        op(MDPS_OP_INC, 16'h0000);
        chk(dataPointer, 16'h0000);
        wr(SFR_SELECT_ADDR, 8'h05);
        @(posedge clock) moveReq <= 1;
        @(posedge clock) moveReq <= 0;
        chk({15'h0000, port2AddrEn}, 16'h0001);
        chk(dataPointer, 16'h055a);
        repeat (2) @(negedge clock);
        chk({8'h00, seenHigh}, 16'h0005);
        $display("ops done");
    endtask
    // Unmapped place is neither read nor written
    task t_unmapped;
        rd(8'h93, 8'h00, 0);
        wr(8'h93, 8'h02);
        rd(SFR_SELECT_ADDR, 8'h05, 1);
        $display("unmapped done");
    endtask
    initial begin
        repeat (3) @(negedge clock);
        nrst = 1;
        rd(SFR_SELECT_ADDR, 8'h00, 1);
        chk(dataPointer, PTR_RESET);
        t_slots();
        t_ops();
        t_unmapped();
        end_of_test();
    end
endmodule
